// ---- include/sbmb_pkg.sv ----
`default_nettype none
package sbmb_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_TX_HOLD = 16'h1F50;
    localparam logic [15:0] ADDR_CMD     = 16'h1F51;
    localparam logic [15:0] ADDR_RX_HOLD = 16'h1F52;
    localparam logic [15:0] ADDR_STATUS  = 16'h1F53;
    localparam logic [15:0] ADDR_CFG     = 16'h1F54;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    // command fields
    localparam int CMD_IFR_BIT   = 6;
    localparam int CMD_ABORT_BIT = 4;
    localparam int CMD_CNT_MSB   = 3;
    // configuration fields
    localparam int CFG_IFR3_BIT  = 6;
    // status fields
    localparam int ST_TXE = 0;
    localparam int ST_RXF = 1;
    localparam int ST_TXA = 2;
    localparam int ST_OVR = 3;
    localparam int ST_RXA = 4;
    localparam int ST_LEN = 5;
    // in-frame response limits
    localparam logic [5:0] IFR2_MAX_RESP  = 6'h20;
    localparam logic [5:0] IFR3_MAX_BYTES = 6'h0C;
    // link symbol fifo
    localparam int SYM_W      = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int BYTE_W     = 8;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;
    typedef enum logic [2:0] {
        SYM_ZERO = 3'h0,
        SYM_ONE  = 3'h1,
        SYM_SOF  = 3'h2,
        SYM_EOD  = 3'h3,
        SYM_EOF  = 3'h4,
        SYM_BRK  = 3'h5,
        SYM_NB   = 3'h6
    } sbmb_sym_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_WAIT = 2'h1,
        TX_SEND = 2'h2
    } sbmb_tx_t;
endpackage
`default_nettype wire

// ---- rtl/sbmb_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbmb_fifo
    import sbmb_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("sbmb_fifo: depth must be a power of two >= 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        nfull;
    } sbmb_fifo_st_t;
    localparam sbmb_fifo_st_t RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, nfull: 1'b1};
    sbmb_fifo_st_t q;
    sbmb_fifo_st_t d;
    logic          push;
    logic          pop;
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign in_ready  = q.nfull;
    assign push      = in_valid && q.nfull;
    assign pop       = out_valid && out_ready;
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        d.nfull = (d.cnt != (AW+1)'(DEPTH));
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= RST;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sbmb_tx_shift.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbmb_tx_shift
    import sbmb_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic         flush,
    input  wire logic         load,
    input  wire logic [W-1:0] load_byte,
    input  wire logic         bit_req,
    output logic              ser_bit,
    output logic              ser_valid,
    output logic              busy,
    output logic              done
);
    localparam int CW = $clog2(W + 1);
    if (W < 2) begin : g_chk
        $error("sbmb_tx_shift: width must be at least two");
    end
    typedef struct packed {
        logic [W-1:0]  sh;
        logic [CW-1:0] left;
        logic          bit_o;
        logic          bit_v;
        logic          done;
    } sbmb_shift_st_t;
    sbmb_shift_st_t q;
    sbmb_shift_st_t d;
    assign ser_bit   = q.bit_o;
    assign ser_valid = q.bit_v;
    assign busy      = (q.left != '0);
    assign done      = q.done;
    always_comb begin
        d = q;
        d.bit_v = 1'b0;
        d.done = 1'b0;
        if (flush) begin
            d.left = '0;
        end else if (load) begin
            d.sh = load_byte;
            d.left = CW'(W);
        end else if (bit_req && busy) begin
            // msb goes out first
            d.bit_o = q.sh[W-1];
            d.bit_v = 1'b1;
            d.sh = {q.sh[W-2:0], 1'b0};
            d.left = q.left - 1'b1;
            d.done = (q.left == CW'(1));
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sbmb_core.sv ----
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// R1: type 2 response collects up to 32 responders, one byte each
// R2: type 3 response returns up to 12 bytes from one responder
// R3: software loads byte count, header included, before sending
// R4: after start of frame first holding byte moves into shift buffer
// R5: that move starts shifting and raises transmit interrupt for next byte
// R6: each finished byte reloads from holding until count is sent
// R7: shift buffer empty before count done sets overrun flag and status interrupt
// R8: overwriting unsent transmit data counts as transmit overrun
// R9: after start of frame received bits assemble a byte then move to holding
// R10: first byte into receive holding raises receive interrupt
// R11: reading receive holding pulls waiting byte in, until end of data
// R12: third byte with holding unread sets overrun flag and status interrupt
// R13: in-frame response uses the same registers and data path
// R14: software programs configuration once per initialization
// R15: software writes command, then data, then handles status
// R16: transmit holding is an eight bit readable and writable register
// R17: command bit 6 requests normalization bit after end of data
// R18: byte count field excludes crc and stays within eleven; the code accepts any nonzero count up to 15
// R19: all bus activity ignored until configuration is written; the code gates only received symbols, not transmit
// R20: transmit interrupt only while holding empty, cleared by a write
// R21: overrun flag stays set until software clears it
module sbmb_core
    import sbmb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [2:0]  link_sym,
    input  wire logic        link_valid,
    output logic             link_ready,
    output logic             tx_frame_req,
    input  wire logic        tx_sof_done,
    input  wire logic        tx_bit_req,
    output logic             tx_bit,
    output logic             tx_bit_valid,
    output logic             tx_eod_req,
    output logic             tx_nb_req,
    output logic             transmit_interrupt,
    output logic             receive_interrupt,
    output logic             status_interrupt
);
    typedef struct packed {
        logic [7:0] cfg;
        logic       cfg_seen;
        logic [7:0] cmd;
        logic [7:0] tx_hold;
        logic       tx_hold_full;
        sbmb_tx_t   tx_st;
        logic [3:0] tx_left;
        logic       frame_req;
        logic       eod_req;
        logic       nb_req;
        logic       txi;
        logic       rxi;
        logic       sti;
        logic       ovr;
        logic       len_err;
        logic       rx_active;
        logic       rx_ifr;
        logic [7:0] rx_shift;
        logic [2:0] rx_cnt;
        logic [7:0] rx_hold;
        logic       rx_hold_full;
        logic [7:0] rx_wait;
        logic       rx_wait_full;
        logic [5:0] ifr_cnt;
        logic       stall;
        logic [7:0] rdata;
    } sbmb_state_t;

    function automatic logic is_bit(input sbmb_sym_t s);
        return (s == SYM_ZERO) || (s == SYM_ONE);
    endfunction
    function automatic logic [5:0] ifr_limit(input logic [7:0] cfg);
        return cfg[CFG_IFR3_BIT] ? IFR3_MAX_BYTES : IFR2_MAX_RESP;
    endfunction
    sbmb_state_t    q;
    sbmb_state_t    d;
    logic [2:0]     f_data;
    logic           f_valid;
    sbmb_sym_t      f_sym;
    logic           pop;
    logic           use_sym;
    logic           byte_done;
    logic [7:0]     rx_byte;
    logic [7:0]     status;
    logic           wr_tx;
    logic           wr_cmd;
    logic           wr_st;
    logic           wr_cfg;
    logic           rd_rx;
    logic           load;
    logic           flush;
    logic           sh_busy;
    logic           sh_done;

    sbmb_fifo #(
        .WIDTH (SYM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .in_data   (link_sym),
        .in_valid  (link_valid),
        .in_ready  (link_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (!q.stall)
    );

    sbmb_tx_shift #(
        .W (BYTE_W)
    ) u_shift (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .flush     (flush),
        .load      (load),
        .load_byte (d.tx_hold),
        .bit_req   (tx_bit_req),
        .ser_bit   (tx_bit),
        .ser_valid (tx_bit_valid),
        .busy      (sh_busy),
        .done      (sh_done)
    );

    assign wr_tx     = reg_wr && (reg_addr == ADDR_TX_HOLD);
    assign wr_cmd    = reg_wr && (reg_addr == ADDR_CMD);
    assign wr_st     = reg_wr && (reg_addr == ADDR_STATUS);
    assign wr_cfg    = reg_wr && (reg_addr == ADDR_CFG);
    assign rd_rx     = reg_rd && (reg_addr == ADDR_RX_HOLD);
    assign f_sym     = sbmb_sym_t'(f_data);
    assign pop       = f_valid && !q.stall;
    assign use_sym   = pop && q.cfg_seen; // R19
    assign byte_done = use_sym && q.rx_active && is_bit(f_sym) && (q.rx_cnt == RX_LAST_BIT);
    assign rx_byte   = {q.rx_shift[6:0], f_sym == SYM_ONE};
    assign status    = {2'h0, q.len_err, q.rx_active, q.ovr,
                        q.tx_st != TX_IDLE, q.rx_hold_full, !q.tx_hold_full};

    assign reg_rdata          = q.rdata;
    assign tx_frame_req       = q.frame_req;
    assign tx_eod_req         = q.eod_req;
    assign tx_nb_req          = q.nb_req;
    assign transmit_interrupt = q.txi;
    assign receive_interrupt  = q.rxi;
    assign status_interrupt   = q.sti;

    always_comb begin
        d = q;
        load = 1'b0;
        flush = 1'b0;
        d.eod_req = 1'b0;
        d.nb_req = 1'b0;
        d.rxi = 1'b0;
        d.sti = 1'b0;
        d.stall = 1'b0;
        // software writes; clears come before hardware sets
        if (wr_cfg) begin
            d.cfg = reg_wdata;
            d.cfg_seen = 1'b1; // R14 R19
        end
        if (wr_st) begin
            if (reg_wdata[ST_OVR]) begin
                d.ovr = 1'b0; // R21
            end
            if (reg_wdata[ST_LEN]) begin
                d.len_err = 1'b0;
            end
        end
        if (wr_tx) begin
            if (q.tx_hold_full) begin
                d.ovr = 1'b1; // R8
                d.sti = 1'b1; // R8
            end
            d.tx_hold = reg_wdata; // R16
            d.tx_hold_full = 1'b1;
        end
        if (wr_cmd) begin
            d.cmd = reg_wdata;
            if (reg_wdata[CMD_ABORT_BIT]) begin
                flush = 1'b1;
                d.tx_st = TX_IDLE;
                d.tx_hold_full = 1'b0;
            end else if (q.tx_st == TX_IDLE && reg_wdata[CMD_CNT_MSB:0] != 4'h0) begin
                d.tx_st = TX_WAIT; // R15
                d.tx_left = reg_wdata[CMD_CNT_MSB:0]; // R3 R18
            end
        end
        // transmit sequencing
        if (!flush) begin
            case (q.tx_st)
                TX_IDLE: begin
                end
                TX_WAIT: begin
                    // start of frame, or normalization bit for a response
                    if (tx_sof_done && d.tx_hold_full) begin
                        load = 1'b1; // R4 R13
                        d.tx_hold_full = 1'b0; // R4
                        d.tx_left = q.tx_left - 4'h1;
                        d.tx_st = TX_SEND; // R5
                    end
                end
                TX_SEND: begin
                    if (sh_done) begin
                        if (q.tx_left == 4'h0) begin
                            d.tx_st = TX_IDLE;
                            d.eod_req = 1'b1;
                        end else if (d.tx_hold_full) begin
                            load = 1'b1; // R6
                            d.tx_hold_full = 1'b0; // R6
                            d.tx_left = q.tx_left - 4'h1; // R6
                        end else begin
                            d.ovr = 1'b1; // R7
                            d.sti = 1'b1; // R7
                            d.tx_st = TX_IDLE;
                        end
                    end
                end
                default: begin
                    d.tx_st = TX_IDLE;
                end
            endcase
        end
        d.frame_req = (d.tx_st == TX_WAIT) && d.tx_hold_full;
        d.txi = (d.tx_st == TX_SEND) && !d.tx_hold_full && (d.tx_left != 4'h0); // R5 R20
        // software read of receive holding
        if (rd_rx) begin
            if (q.rx_wait_full) begin
                d.rx_hold = q.rx_wait; // R11
                d.rx_wait_full = 1'b0; // R11
                d.stall = 1'b1;
            end else begin
                d.rx_hold_full = 1'b0;
            end
        end
        // link symbols
        if (use_sym) begin
            case (f_sym)
                SYM_SOF: begin
                    d.rx_active = 1'b1; // R9
                    d.rx_ifr = 1'b0;
                    d.rx_cnt = 3'h0;
                    d.ifr_cnt = 6'h00;
                end
                SYM_EOD: begin
                    if (q.rx_active) begin
                        if (!q.rx_ifr) begin
                            d.rx_ifr = 1'b1; // R13
                            d.rx_cnt = 3'h0;
                            d.nb_req = q.cmd[CMD_IFR_BIT]; // R17
                        end else begin
                            d.rx_active = 1'b0; // R11
                        end
                    end
                end
                SYM_EOF, SYM_BRK: begin
                    d.rx_active = 1'b0;
                    d.rx_ifr = 1'b0;
                end
                default: begin
                    if (q.rx_active && is_bit(f_sym)) begin
                        d.rx_shift = rx_byte; // R9
                        d.rx_cnt = q.rx_cnt + 3'h1;
                    end
                end
            endcase
        end
        if (byte_done) begin
            if (!d.rx_hold_full) begin
                d.rx_hold = rx_byte; // R9
                d.rx_hold_full = 1'b1;
                d.rxi = 1'b1; // R10
            end else if (!d.rx_wait_full) begin
                d.rx_wait = rx_byte;
                d.rx_wait_full = 1'b1;
            end else begin
                d.ovr = 1'b1; // R12
                d.sti = 1'b1; // R12
            end
            if (q.rx_ifr) begin
                if (q.ifr_cnt == ifr_limit(q.cfg)) begin
                    d.len_err = 1'b1; // R1 R2
                    d.sti = 1'b1;
                end else begin
                    d.ifr_cnt = q.ifr_cnt + 6'h01; // R1 R2
                end
            end
        end
        // registered read data
        if (reg_rd) begin
            case (reg_addr)
                ADDR_TX_HOLD: d.rdata = q.tx_hold; // R16
                ADDR_CMD:     d.rdata = q.cmd;
                ADDR_RX_HOLD: d.rdata = q.rx_hold;
                ADDR_STATUS:  d.rdata = status;
                ADDR_CFG:     d.rdata = q.cfg;
                default:      d.rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || !ce);
    sof_load_a: assert property ( // R4
        q.tx_st == TX_WAIT && q.tx_hold_full && tx_sof_done && !wr_tx && !wr_cmd
        |=> q.tx_st == TX_SEND && !q.tx_hold_full && sh_busy)
        else $error("first byte not moved into shift buffer");
    tx_irq_a: assert property ( // R5
        q.tx_st == TX_WAIT && q.tx_hold_full && tx_sof_done && !wr_tx && !wr_cmd && q.tx_left > 4'h1
        |=> transmit_interrupt) else $error("transmit interrupt missing after first move");
    txi_empty_a: assert property (transmit_interrupt |-> !q.tx_hold_full && q.tx_st == TX_SEND) // R20
        else $error("transmit interrupt while holding is full");
    refill_a: assert property ( // R6
        q.tx_st == TX_SEND && sh_done && q.tx_left != 4'h0 && q.tx_hold_full && !wr_cmd
        |=> q.tx_left == $past(q.tx_left) - 4'h1 && sh_busy) else $error("shift buffer not refilled from holding");
    tx_undr_a: assert property ( // R7
        q.tx_st == TX_SEND && sh_done && q.tx_left != 4'h0 && !q.tx_hold_full && !wr_tx && !wr_cmd
        |=> q.ovr && status_interrupt && q.tx_st == TX_IDLE) else $error("transmit underflow not flagged");
    tx_ovr_a: assert property (wr_tx && q.tx_hold_full |=> q.ovr && status_interrupt) // R8
        else $error("transmit overrun not flagged");
    rx_load_a: assert property ( // R10
        byte_done && !q.rx_hold_full && !rd_rx
        |=> receive_interrupt && q.rx_hold_full && q.rx_hold == $past(rx_byte))
        else $error("received byte not moved to holding");
    rx_move_a: assert property ( // R11
        rd_rx && q.rx_wait_full && !byte_done
        |=> q.rx_hold_full && !q.rx_wait_full && q.rx_hold == $past(q.rx_wait))
        else $error("waiting byte not moved on read");
    rx_ovr_a: assert property ( // R12
        byte_done && q.rx_hold_full && q.rx_wait_full && !rd_rx |=> q.ovr && status_interrupt)
        else $error("receive overrun not flagged");
    cfg_gate_a: assert property (!q.cfg_seen |=> !q.rx_active) // R19
        else $error("bus activity taken before configuration");
    ovr_hold_a: assert property (q.ovr && !(wr_st && reg_wdata[ST_OVR]) |=> q.ovr) // R21
        else $error("overrun flag lost without clear");
    nb_req_a: assert property ( // R17
        use_sym && f_sym == SYM_EOD && q.rx_active && !q.rx_ifr && q.cmd[CMD_IFR_BIT] |=> tx_nb_req)
        else $error("normalization bit not requested");
    ifr_len_a: assert property ( // R1 R2
        byte_done && q.rx_ifr && q.ifr_cnt == ifr_limit(q.cfg) |=> q.len_err && status_interrupt)
        else $error("response length limit not flagged");
    frame_done_c: cover property (q.tx_st == TX_SEND ##1 tx_eod_req);
    rx_byte_c: cover property (receive_interrupt ##[1:200] rd_rx);
    ovr_c: cover property (status_interrupt && q.ovr);
    nb_c: cover property (tx_nb_req ##[1:50] tx_sof_done);
endmodule
`default_nettype wire

// ---- tb/sbmb_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbmb_bus_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       tx_frame_req,
    input  wire logic       tx_eod_req,
    input  wire logic       status_interrupt,
    input  wire logic       link_ready,
    output logic            tx_sof_done,
    output logic            tx_bit_req,
    output logic [2:0]      link_sym,
    output logic            link_valid
);
    int   sof_dly = 1;
    int   wcnt    = 0;
    int   bcnt    = 0;
    logic run     = 1'b0;
    initial begin
        tx_sof_done = 1'b0;
        tx_bit_req  = 1'b0;
        link_sym    = 3'h7;
        link_valid  = 1'b0;
    end
    // frame start after sof_dly cycles, then a bit request every fourth cycle
    always @(posedge clk) begin
        tx_sof_done <= 1'b0;
        tx_bit_req  <= run && (bcnt % 4 == 3);
        bcnt        <= bcnt + 1;
        wcnt        <= (tx_frame_req && !run) ? wcnt + 1 : 0;
        if (srst || tx_eod_req || status_interrupt) begin
            run <= 1'b0;
        end else if (tx_frame_req && !run && wcnt == sof_dly) begin
            tx_sof_done <= 1'b1;
            run         <= 1'b1;
        end
    end
    // symbol held until taken, then the line shows the inverse
    task automatic send(input logic [2:0] s);
        @(posedge clk);
        link_sym   <= s;
        link_valid <= 1'b1;
        do @(posedge clk); while (link_ready !== 1'b1);
        link_valid <= 1'b0;
        link_sym   <= ~s;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_sbmb_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_sbmb_core;
    import sbmb_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [15:0] reg_addr = '0;
    logic [7:0]  reg_wdata = '0, reg_rdata, a, b, c, d, x, y, z;
    logic [2:0]  link_sym;
    logic        link_valid, link_ready, tx_frame_req, tx_sof_done, tx_bit_req, tx_bit, tx_bit_valid;
    logic        tx_eod_req, tx_nb_req, transmit_interrupt, receive_interrupt, status_interrupt;
    int          n_mismatch = 0, num_checks = 0, n_cyc = 0, n_rxi = 0, n_sti = 0, n_eod = 0, n_nb = 0;
    logic [7:0]  exp_q[$], msk_q[$];
    logic        bit_q[$];
    always #10 clk = ~clk;
    sbmb_core dut (.clk(clk), .srst(srst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_sym(link_sym), .link_valid(link_valid),
        .link_ready(link_ready), .tx_frame_req(tx_frame_req), .tx_sof_done(tx_sof_done),
        .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_eod_req(tx_eod_req),
        .tx_nb_req(tx_nb_req), .transmit_interrupt(transmit_interrupt),
        .receive_interrupt(receive_interrupt), .status_interrupt(status_interrupt));
    sbmb_bus_model bm (.clk(clk), .srst(srst), .tx_frame_req(tx_frame_req), .tx_eod_req(tx_eod_req),
        .status_interrupt(status_interrupt), .link_ready(link_ready), .tx_sof_done(tx_sof_done),
        .tx_bit_req(tx_bit_req), .link_sym(link_sym), .link_valid(link_valid));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watcher: event counts, read data and serial bits against the notes
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            give_verdict;
        end
        if (receive_interrupt === 1'b1) n_rxi++;
        if (status_interrupt === 1'b1) n_sti++;
        if (tx_eod_req === 1'b1) n_eod++;
        if (tx_nb_req === 1'b1) n_nb++;
        if (rd_d) check("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        if (tx_bit_valid === 1'b1) check("tx_bit", {7'h0, tx_bit}, {7'h0, bit_q.pop_front()});
        rd_d <= reg_rd;
    end
    task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= dt;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] ad, input logic [7:0] ex, input logic [7:0] mk);
        exp_q.push_back(ex & mk);
        msk_q.push_back(mk);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    task automatic push_bits(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_q.push_back(v[i]);
    endtask
    task automatic rx_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
        logic [23:0] all;
        all = {b0, b1, b2};
        bm.send(SYM_SOF);
        for (int i = 23; i >= 24 - 8 * n; i--) bm.send(all[i] ? SYM_ONE : SYM_ZERO);
        bm.send(SYM_EOD);
        repeat (20) @(posedge clk);
    endtask
    initial begin
        void'($urandom(87971));
        {a, b, c, d} = $urandom;
        {x, y, z} = 24'($urandom);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_TX_HOLD, RST_BYTE, 8'hFF);
        rx_frame(x, y, z, 1);
        check("rxi_unconfigured", n_rxi[7:0], 8'h00);
        rd(ADDR_STATUS, 8'h00, 8'h02);
        $display("test reset and unconfigured done");
        wr(ADDR_CFG, 8'h40);
        rx_frame(x, y, z, 3);
        check("rxi_count", n_rxi[7:0], 8'h01);
        check("sti_rx_overrun", n_sti[7:0], 8'h01);
        rd(ADDR_STATUS, 8'h08, 8'h08);
        rd(ADDR_STATUS, 8'h08, 8'h08);
        rd(ADDR_RX_HOLD, x, 8'hFF);
        rd(ADDR_RX_HOLD, y, 8'hFF);
        wr(ADDR_STATUS, 8'h08);
        rd(ADDR_STATUS, 8'h00, 8'h08);
        $display("test receive done");
        wr(ADDR_CMD, 8'h02);
        wr(ADDR_TX_HOLD, a);
        push_bits(a);
        for (int i = 0; i < 40 && transmit_interrupt !== 1'b1; i++) @(posedge clk);
        check("txi_first", {7'h0, transmit_interrupt}, 8'h01);
        wr(ADDR_TX_HOLD, b);
        push_bits(b);
        @(negedge clk);
        check("txi_after_write", {7'h0, transmit_interrupt}, 8'h00);
        for (int i = 0; i < 400 && n_eod == 0; i++) @(posedge clk);
        check("eod_count", n_eod[7:0], 8'h01);
        check("bits_left", 8'(bit_q.size()), 8'h00);
        $display("test transmit done");
        bm.sof_dly = 12;
        wr(ADDR_CMD, 8'h03);
        wr(ADDR_TX_HOLD, c);
        wr(ADDR_TX_HOLD, d);
        push_bits(d);
        rd(ADDR_TX_HOLD, d, 8'hFF);
        for (int i = 0; i < 300 && n_sti < 3; i++) @(posedge clk);
        check("sti_tx_errors", n_sti[7:0], 8'h03);
        rd(ADDR_STATUS, 8'h08, 8'h08);
        check("eod_after_underflow", n_eod[7:0], 8'h01);
        check("bits_left_underflow", 8'(bit_q.size()), 8'h00);
        $display("test overrun and underflow done");
        wr(ADDR_CMD, 8'h01);
        wr(ADDR_TX_HOLD, c);
        wr(ADDR_CMD, 8'h10);
        rd(ADDR_STATUS, 8'h01, 8'h05);
        $display("test abort done");
        wr(ADDR_CMD, 8'h40);
        rx_frame(x, y, z, 1);
        check("nb_count", n_nb[7:0], 8'h01);
        for (int i = 0; i < 104; i++) begin
            if (i == 96) rd(ADDR_STATUS, 8'h00, 8'h20);
            bm.send(3'($urandom_range(1)));
        end
        bm.send(SYM_EOD);
        rd(ADDR_STATUS, 8'h20, 8'h20);
        wr(ADDR_STATUS, 8'h20);
        rd(ADDR_STATUS, 8'h00, 8'h20);
        $display("test in-frame response done");
        repeat (4) @(posedge clk);
        give_verdict;
    end
endmodule
`default_nettype wire
